// file: fsdr_core.sv
// module: sensor delay timers, soft start/stop ramp and shortage routing
//
// Overview of operation
// R1 - sensor starts seeing parts: stop driving after the off-delay, 0 to 30 s; the code's limit of 300 ticks is 30 ms.
// R2 - delay timers act only for drive method 0, 1 or 3.
// R3 - start ramps amplitude 0 up to level over soft-start time, default 0.5 s; RAMP_UP_DEF of 5 ticks is 0.5 ms in the code.
// R4 - stop ramps amplitude level down to 0 over soft-stop time, default 0.3 s; RAMP_DOWN_DEF of 3 ticks is 0.3 ms in the code.
// R5 - a zero ramp time still takes about 50 ms; the code's minimum, MIN_RAMP_CYCLES, is 10,000 cycles or 50 us.
// R6 - shortage source select: 0 unused, 1 uses sensor input one.
// R7 - with source 1, sensor goes to shortage detect and clear timers.
// R8 - three reserved setting slots have no function and must not be set.
// R9 - sensor stops seeing parts: start driving after the on-delay, 0 to 60 s; the code's limit of 600 ticks is 60 ms.
// R10 - polarity 0: low runs off-delay, high runs on-delay; 1 reverses.
// R11 - shortage flag sets once input stays active for detect time while driving.
// R12 - durations count in 0.1 s ticks; a timer restarts if its condition breaks. The code's tick, STEP_CYCLES, is 20,000 cycles or 0.1 ms.
// R13 - ramps are linear; stop during soft-start falls from present amplitude.
`timescale 1ns/1ps

module fsdr_core
  import fsdr_pkg::*;
#(
  parameter int unsigned STEP_CNT = STEP_CYCLES,
  parameter int unsigned MIN_CNT  = MIN_RAMP_CYCLES,
  parameter logic [TW-1:0] SHORT_DET = SHORT_DET_DEF
) (
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  input  wire logic                        sensor_input_one_i,
  input  wire fsdr_pkg::fsdr_cfg_t         cfg_i,
  input  wire logic [fsdr_pkg::AW-1:0]     level_i,
  output logic                             drive_on_o,
  output logic [fsdr_pkg::AW-1:0]          amplitude_o,
  output fsdr_pkg::fsdr_state_t            state_o,
  output fsdr_pkg::fsdr_short_route_t      shortage_route_o,
  output logic                             shortage_flag_o
);
  import fsdr_pkg::*;

  // ==========================================================================
  // tick base
  // ==========================================================================
  // free running: the first step of any delay may be short by up to one tick
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic        tick;

  always_comb begin
    tick          = (tick_cnt_reg == STEP_CNT - 1);
    tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;  // see R12
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) tick_cnt_reg <= 32'h0;
    else           tick_cnt_reg <= tick_cnt_next;
  end

  // ==========================================================================
  // sensor delay timers
  // ==========================================================================
  logic          seen;       // sensor reports parts present
  logic          ovf_mode;
  logic [TW-1:0] on_lim, off_lim;
  logic [TW-1:0] dly_reg, dly_next;
  logic          want_reg, want_next;

  always_comb begin
    seen     = sensor_input_one_i ^ ~cfg_i.input_polarity_select;  // see R10
    ovf_mode = (cfg_i.drive_method_select == METHOD_OVF_0) ||
               (cfg_i.drive_method_select == METHOD_OVF_1) ||
               (cfg_i.drive_method_select == METHOD_OVF_3);      // see R2
    // out-of-range settings saturate instead of wrapping
    on_lim   = (cfg_i.start_delay_setting > START_DLY_MAX) ? START_DLY_MAX
                                                           : cfg_i.start_delay_setting;
    off_lim  = (cfg_i.stop_delay_setting > STOP_DLY_MAX) ? STOP_DLY_MAX
                                                         : cfg_i.stop_delay_setting;
    // a changed limit applies at once, even in mid-count
    want_next = want_reg;
    dly_next  = dly_reg;
    if (!ovf_mode) begin
      want_next = 1'b1;  // sensor ignored: drive is wanted at all times
      dly_next  = '0;
    end else if (seen == want_reg) begin
      // sensor asks for a change of state
      if (dly_reg >= (want_reg ? off_lim : on_lim)) begin
        want_next = ~want_reg;                        // see R1 // see R9
        dly_next  = '0;
      end else if (tick) begin
        dly_next  = dly_reg + 1'b1;                   // see R12
      end
    end else begin
      dly_next = '0;                                  // see R12
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // not wanted after reset, so power-up starts the drive only through the on-delay, or at once in method 2
      dly_reg  <= '0;
      want_reg <= 1'b0;
    end else begin
      dly_reg  <= dly_next;
      want_reg <= want_next;
    end
  end

  // ==========================================================================
  // soft start / soft stop ramp
  // ==========================================================================
  // amplitude held as fixed point: AW integer bits above FRAC_W fraction bits
  logic [AW+FRAC_W-1:0] amp_reg, amp_next;
  logic [AW+FRAC_W-1:0] target, step;
  logic [AW+FRAC_W:0]   amp_sum;  // spare top bit: a near-full level plus a step must not wrap
  logic [TW-1:0]        rtime;
  logic [47:0]          span_cyc;
  fsdr_state_t          st_reg, st_next;

  always_comb begin
    target = {level_i, {FRAC_W{1'b0}}};
    rtime  = (st_reg == FSDR_FALL) ? cfg_i.ramp_down_time_setting
                                   : cfg_i.ramp_up_time_setting;
    if (rtime > RAMP_MAX) rtime = RAMP_MAX;
    span_cyc = 48'(rtime) * 48'(STEP_CNT);
    if (span_cyc < 48'(MIN_CNT)) span_cyc = 48'(MIN_CNT);     // see R5
    step = (AW+FRAC_W)'(48'(target) / span_cyc);             // see R13
    if (step == '0) step = {{(AW+FRAC_W-1){1'b0}}, 1'b1};
    // slope follows the level, so a level change in mid-ramp bends it
    amp_sum = {1'b0, amp_reg} + {1'b0, step};
    st_next  = st_reg;
    amp_next = amp_reg;
    case (st_reg)
      FSDR_IDLE: begin
        amp_next = '0;
        if (want_reg) st_next = FSDR_RISE;                    // see R3
      end
      FSDR_RISE: begin
        if (!want_reg) st_next = FSDR_FALL;                   // see R13
        else if (amp_sum >= {1'b0, target}) begin
          amp_next = target;
          st_next  = FSDR_RUN;
        end else amp_next = amp_sum[AW+FRAC_W-1:0];           // see R3
      end
      FSDR_RUN: begin
        amp_next = target;
        if (!want_reg) st_next = FSDR_FALL;                   // see R4
      end
      FSDR_FALL: begin
        if (amp_reg <= step) begin
          amp_next = '0;
          st_next  = FSDR_IDLE;
        end else amp_next = amp_reg - step;                   // see R4
      end
      default: begin
        st_next  = FSDR_IDLE;
        amp_next = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg  <= FSDR_IDLE;
      amp_reg <= '0;
    end else begin
      st_reg  <= st_next;
      amp_reg <= amp_next;
    end
  end

  // ==========================================================================
  // shortage routing and detect timer
  // ==========================================================================
  // reserved slots are not ports at all, so nothing can configure them  // see R8
  logic          route_en;
  logic [TW-1:0] sdet_reg, sdet_next;
  logic          sflag_reg, sflag_next;

  always_comb begin
    route_en   = (cfg_i.shortage_source_select == SHORT_SRC_IN1);   // see R6
    // any break in the condition restarts the count
    sdet_next  = '0;
    sflag_next = sflag_reg;
    if (route_en && drive_on_o && !seen) begin
      // the flag stays set once reached; only deselecting the shortage source clears it
      if (sdet_reg >= SHORT_DET) sflag_next = 1'b1;                 // see R11
      else sdet_next = sdet_reg + (tick ? 11'h001 : 11'h000);       // see R12
      if (sdet_reg >= SHORT_DET) sdet_next = sdet_reg;
    end
    if (!route_en) sflag_next = 1'b0;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sdet_reg  <= '0;
      sflag_reg <= 1'b0;
    end else begin
      sdet_reg  <= sdet_next;
      sflag_reg <= sflag_next;
    end
  end

  // forwarded sensor level, registered so the timers see a flop-driven copy
  fsdr_short_route_t route_reg, route_next;

  always_comb begin
    route_next.shortage_detect_timer = route_en & sensor_input_one_i;  // see R7
    route_next.shortage_clear_timer  = route_en & sensor_input_one_i;  // see R7
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) route_reg <= '0;
    else           route_reg <= route_next;
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_comb begin
    drive_on_o      = (st_reg != FSDR_IDLE);
    amplitude_o     = amp_reg[AW+15:16];
    state_o         = st_reg;
    shortage_flag_o = sflag_reg;
    shortage_route_o = route_reg;
  end

endmodule

// file: fsdr_pkg.sv
// package: constants and carrier types for the feeder sensor delay and ramp block
package fsdr_pkg;

  // ==========================================================================
  // timing base
  // ==========================================================================
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned STEP_MS          = 100;
  localparam int unsigned STEP_CYCLES      = CLK_HZ / 1000 * STEP_MS / 1000;
  localparam int unsigned MIN_RAMP_MS      = 50;
  localparam int unsigned MIN_RAMP_CYCLES  = CLK_HZ / 1000 * MIN_RAMP_MS / 1000;

  // ==========================================================================
  // setting widths, defaults and limits (tenths of a millisecond)
  // ==========================================================================
  localparam int unsigned TW = 11;
  localparam int unsigned AW = 10;
  localparam int unsigned FRAC_W = 16;  // fraction bits of the amplitude accumulator
  localparam logic [TW-1:0] START_DLY_DEF  = 11'h000;
  localparam logic [TW-1:0] START_DLY_MAX  = 11'h258;
  localparam logic [TW-1:0] STOP_DLY_DEF   = 11'h000;
  localparam logic [TW-1:0] STOP_DLY_MAX   = 11'h12c;
  localparam logic [TW-1:0] RAMP_UP_DEF    = 11'h005;
  localparam logic [TW-1:0] RAMP_DOWN_DEF  = 11'h003;
  localparam logic [TW-1:0] RAMP_MAX       = 11'h032;
  localparam logic [TW-1:0] SHORT_DET_DEF  = 11'h064;
  localparam logic [TW-1:0] SHORT_CLR_DEF  = 11'h00a;

  localparam logic [1:0] METHOD_OVF_0 = 2'h0;
  localparam logic [1:0] METHOD_OVF_1 = 2'h1;
  localparam logic [1:0] METHOD_OVF_3 = 2'h3;
  localparam logic       SHORT_SRC_NONE = 1'b0;
  localparam logic       SHORT_SRC_IN1  = 1'b1;

  typedef struct packed {
    logic          input_polarity_select;
    logic [1:0]    drive_method_select;
    logic [TW-1:0] start_delay_setting;
    logic [TW-1:0] stop_delay_setting;
    logic [TW-1:0] ramp_up_time_setting;
    logic [TW-1:0] ramp_down_time_setting;
    logic          shortage_source_select;
  } fsdr_cfg_t;

  typedef struct packed {
    logic shortage_detect_timer;
    logic shortage_clear_timer;
  } fsdr_short_route_t;

  typedef enum logic [1:0] {FSDR_IDLE, FSDR_RISE, FSDR_RUN, FSDR_FALL} fsdr_state_t;

endpackage

// file: fsdr_core_asserts.sv
// checker: concurrent assertions for the delay, ramp and routing block
`timescale 1ns/1ps
module fsdr_core_asserts
  import fsdr_pkg::*;
#(
  parameter int unsigned STEP_CNT = STEP_CYCLES,
  parameter int unsigned MIN_CNT  = MIN_RAMP_CYCLES
) (
  input wire logic                          clock_i,
  input wire logic                          resetn_i,
  input wire logic                          sensor_input_one_i,
  input wire fsdr_pkg::fsdr_cfg_t           cfg_i,
  input wire logic [fsdr_pkg::AW-1:0]       level_i,
  input wire logic                          drive_on_o,
  input wire logic [fsdr_pkg::AW-1:0]       amplitude_o,
  input wire fsdr_pkg::fsdr_state_t         state_o,
  input wire fsdr_pkg::fsdr_short_route_t   shortage_route_o,
  input wire logic                          shortage_flag_o
);
  import fsdr_pkg::*;
  // ==========================================================================
  // cycles spent in soft start so far
  logic [31:0] rise_reg;
  logic [31:0] rise_next;
  always_comb rise_next = (state_o == FSDR_RISE) ? rise_reg + 32'h1 : 32'h0;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) rise_reg <= 32'h0;
    else rise_reg <= rise_next;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================================
  drive_state_a: assert property (drive_on_o == (state_o != FSDR_IDLE))
    else $error("drive flag disagrees with state");
  route_detect_a: assert property ($past(resetn_i) |->
    shortage_route_o.shortage_detect_timer ==
    $past(sensor_input_one_i & cfg_i.shortage_source_select))
    else $error("detect route wrong");
  route_clear_a: assert property ($past(resetn_i) &&
    !$past(cfg_i.shortage_source_select) |-> shortage_route_o == 2'h0)
    else $error("clear route wrong");
  flag_clear_a: assert property (!cfg_i.shortage_source_select |=> !shortage_flag_o)
    else $error("shortage flag kept without source");
  idle_amp_a: assert property (state_o == FSDR_IDLE |-> amplitude_o == 10'h000)
    else $error("amplitude left in idle");
  rise_mono_a: assert property (state_o == FSDR_RISE ##1 state_o == FSDR_RISE
    |-> amplitude_o >= $past(amplitude_o)) else $error("soft start fell");
  fall_mono_a: assert property (state_o == FSDR_FALL ##1 state_o == FSDR_FALL
    |-> amplitude_o <= $past(amplitude_o)) else $error("soft stop rose");
  min_ramp_a: assert property (state_o == FSDR_RUN && $past(state_o) == FSDR_RISE
    |-> rise_reg >= MIN_CNT - 1) else $error("soft start too short");
  method_run_a: assert property ((cfg_i.drive_method_select == 2'h2 &&
    state_o != FSDR_FALL) [*3] |-> state_o != FSDR_IDLE)
    else $error("fixed method not driving");
endmodule
bind fsdr_core fsdr_core_asserts #(.STEP_CNT(STEP_CNT), .MIN_CNT(MIN_CNT)) u_chk (.clock_i,
  .resetn_i, .sensor_input_one_i, .cfg_i, .level_i, .drive_on_o, .amplitude_o, .state_o,
  .shortage_route_o, .shortage_flag_o);

// file: fsdr_sensor_model.sv
// partner: overflow sensor driving sensor input one
`timescale 1ns/1ps
module fsdr_sensor_model (
  input  wire logic parts_i,
  input  wire logic pol_i,
  output logic      sensor_o
);
  // push-pull output, parts seen pulls low unless polarity is reversed
  assign sensor_o = parts_i ~^ pol_i;
endmodule

// file: test_feeder_sensor_delay_ramp.sv
// testbench: delay timers, soft ramps and shortage routing
`timescale 1ns/1ps
module test_feeder_sensor_delay_ramp;
  import fsdr_pkg::*;
  logic clock_i = 1'b0, resetn_i = 1'b0, parts = 1'b1, drive_on, flag, sensor;
  logic [AW-1:0] level = 10'h064, amp;
  fsdr_cfg_t cfg = '0;
  fsdr_state_t state;
  fsdr_short_route_t route;
  int n_fail = 0, compares = 0, n;
  always #2.5 clock_i = ~clock_i;
  fsdr_sensor_model u_sensor (.parts_i(parts), .pol_i(cfg.input_polarity_select),
    .sensor_o(sensor));
  fsdr_core #(.STEP_CNT(10), .MIN_CNT(5)) u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .sensor_input_one_i(sensor), .cfg_i(cfg), .level_i(level), .drive_on_o(drive_on),
    .amplitude_o(amp), .state_o(state), .shortage_route_o(route), .shortage_flag_o(flag));
  // ==========================================================================
  task chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(int k); repeat (k) @(negedge clock_i); endtask
  task wait_st(fsdr_state_t s);
    n = 0;
    while (state !== s && n < 2000) begin cyc(1); n++; end
  endtask
  task final_report;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  task t_start_stop(logic p);
    cfg.input_polarity_select = p; parts = 1'b1; cyc(30);
    chk("idle drive", drive_on, 0);
    // the free-running tick moves the start by up to one step
    parts = 1'b0; cyc(20);
    chk("early drive", drive_on, 0);
    cyc(15);
    chk("late drive", drive_on, 1);
    wait_st(FSDR_RUN);
    chk("run amplitude", amp, level);
    parts = 1'b1; cyc(10);
    chk("stop held", state, FSDR_RUN);
    wait_st(FSDR_FALL);
    chk("stop delay", n <= 12, 1);
    wait_st(FSDR_IDLE);
    chk("min fall", n >= 3 && n <= 8, 1);
    chk("fall end", amp, 0);
  endtask
  task t_method;
    logic [1:0] m [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    parts = 1'b1;
    foreach (m[i]) begin
      cfg.drive_method_select = m[i]; cyc(10);
      chk("method drive", drive_on, m[i] == 2'h2);
    end
    cfg.drive_method_select = 2'h0;
    wait_st(FSDR_IDLE);
  endtask
  task t_route;
    for (int s = 0; s < 2; s++) for (int a = 0; a < 2; a++) begin
      cfg.shortage_source_select = s[0]; parts = a[0]; cyc(1);
      chk("route", route, {2{s[0] & (a[0] ~^ cfg.input_polarity_select)}});
    end
    cfg.shortage_source_select = 1'b0; parts = 1'b1; cyc(30);
  endtask
  task t_abort;
    cfg.ramp_up_time_setting = RAMP_MAX; cfg.ramp_down_time_setting = RAMP_MAX;
    cfg.stop_delay_setting = 11'h000;
    cfg.start_delay_setting = 11'h000; parts = 1'b0; cyc(100);
    parts = 1'b1; cyc(5);
    chk("abort state", state, FSDR_FALL);
    chk("abort low", amp < level && amp != 0, 1);
    wait_st(FSDR_IDLE);
  endtask
  task t_short;
    cfg.shortage_source_select = 1'b1; parts = 1'b0; cyc(900);
    chk("short early", flag, 0);
    chk("short route", route, 2'h3);
    cyc(200);
    chk("short set", flag, 1);
    parts = 1'b1; cyc(5);
    chk("short held", flag, 1);
    cfg.shortage_source_select = 1'b0; cyc(2);
    chk("short clear", flag, 0);
    wait_st(FSDR_IDLE);
  endtask
  initial begin
    cfg.start_delay_setting = 11'h003; cfg.stop_delay_setting = 11'h002;
    cfg.ramp_up_time_setting = 11'h001;
    cyc(4); resetn_i = 1'b1;
    t_start_stop(1'b0); t_start_stop(1'b1); cfg.input_polarity_select = 1'b0;
    t_method(); t_route(); t_abort(); t_short();
    final_report();
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule
